// file: verif/tb_top.sv
// tb_top: frame sequences through the front end against worked-out results.
// assumes the encoder model drives the frame port and the bench the result port.
`timescale 1ns/1ps
module tb_top;
	logic clk;
	logic nrst;
	logic in_valid;
	logic in_ready;
	logic signed [vafe_pkg::ACF_W-1:0] frame_autocorr [vafe_pkg::NCOEF];
	logic [vafe_pkg::LAG_W-1:0] pitch_lag [4];
	logic [vafe_pkg::ENERGY_W-1:0] decision_threshold;
	logic adapt_enable;
	logic out_valid;
	logic out_ready;
	logic [vafe_pkg::ENERGY_W-1:0] filtered_energy;
	logic steady_spectrum_flag;
	logic periodic_flag;
	logic speech_flag;
	int errors;
	int compares;
	bit ok;
	// six, one, two and a half and three quarter times the large autocorrelation
	localparam logic [63:0] E6 = 64'h0000_0001_8000_0000;
	localparam logic [63:0] E1 = 64'h0000_0000_4000_0000;
	localparam logic [63:0] E25 = 64'h0000_0000_a000_0000;
	localparam logic [63:0] E075 = 64'h0000_0000_3000_0000;
	localparam logic signed [31:0] BIG = 32'h4000_0000;
	vafe_front_end #(.BUF_DEPTH(2)) dut (.clk, .nrst, .in_valid, .in_ready, .frame_autocorr, .pitch_lag,
		.decision_threshold, .adapt_enable, .out_valid, .out_ready, .filtered_energy,
		.steady_spectrum_flag, .periodic_flag, .speech_flag);
	vafe_enc_model enc (.clk, .in_ready, .in_valid, .frame_autocorr, .pitch_lag);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] want);
		compares++;
		if (got !== want) begin
			errors++;
			$display("mismatch at %0t: got %0h want %0h", $time, got, want);
		end
	endtask
	// take one word; a bound that runs out counts as a mismatch
	task automatic recv(input logic [63:0] e, input logic [2:0] f);
		int n;
		bit got;
		got = 1'b0;
		out_ready = 1'b1;
		for (n = 0; n < 64 && !got; n++) begin
			got = (out_valid === 1'b1);
			if (got) begin
				chk(filtered_energy, e);
				chk(64'(steady_spectrum_flag), 64'(f[2]));
				chk(64'(periodic_flag), 64'(f[1]));
				chk(64'(speech_flag), 64'(f[0]));
			end
			@(posedge clk);
			#1;
		end
		out_ready = 1'b0;
		chk(64'(got), 64'h1);
		// one idle edge, so a following call never drives out_ready twice in one step
		@(posedge clk);
		#1;
	endtask
	task automatic run(input logic signed [31:0] a0, a1, a2, input logic [31:0] lg, input logic [63:0] thr, e,
		input logic [2:0] f);
		decision_threshold = thr;
		enc.send(a0, a1, a2, lg, ok);
		chk(64'(ok), 64'h1);
		recv(e, f);
	endtask
	task automatic rst();
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(64'({in_ready, out_valid}), 64'h2);
		nrst = 1'b1;
	endtask
	task automatic complete_run();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		errors = 0;
		compares = 0;
		out_ready = 1'b0;
		adapt_enable = 1'b0;
		decision_threshold = 64'h0;
		// reset starts after time zero so its asynchronous edge is not lost in start-up order
		#1;
		rst();
		// no permission: the start filter stays, threshold just below and then equal to the energy
		run(32'h3e8, 32'h64, 32'h32, 32'h3928_3928, 64'h14b3, 64'h14b4, 3'b001);
		run(32'h3e8, 32'h64, 32'h32, 32'h3928_3928, 64'h14b4, 64'h14b4, 3'b100);
		run(32'h3e8, 32'h64, 32'h32, 32'h3928_3928, 64'h14b3, 64'h14b4, 3'b101);
		// fresh history, buffer filled while the receiver stalls
		rst();
		adapt_enable = 1'b1;
		enc.send(BIG, 32'h0, 32'h0, 32'h5028_2828, ok);
		chk(64'(ok), 64'h1);
		enc.send(BIG, 32'h0, 32'h0, 32'h3939_3939, ok);
		chk(64'(ok), 64'h1);
		enc.send(BIG, 32'h0, 32'h0, 32'h0000_0000, ok);
		repeat (20) @(posedge clk);
		#1;
		chk(64'({ok, in_ready}), 64'h2);
		recv(E6, 3'b001);
		recv(E6, 3'b111);
		recv(E6, 3'b111);
		run(BIG, 32'h0, 32'h0, 32'h3939_3939, 64'h0, E6, 3'b101);
		run(BIG, 32'h0, 32'h0, 32'h3939_3939, 64'h0, E1, 3'b101);
		run(BIG, 32'h0, 32'h0, 32'h2829_282a, 64'h0, E1, 3'b111);
		run(BIG, 32'h0, 32'h0, 32'h5439_0000, 64'h0, E1, 3'b111);
		run(BIG, 32'h0, 32'h0, 32'h3939_3939, 64'h0, E1, 3'b101);
		// halving spectrum: the delayed sums give a first coefficient of minus one half, the rest zero
		rst();
		run(BIG, 32'h2000_0000, 32'h1000_0000, 32'h3928_3928, 64'h0, E25, 3'b001);
		run(BIG, 32'h2000_0000, 32'h1000_0000, 32'h3928_3928, 64'h0, E25, 3'b101);
		run(BIG, 32'h2000_0000, 32'h1000_0000, 32'h3928_3928, 64'h0, E1, 3'b101);
		run(BIG, 32'h2000_0000, 32'h1000_0000, 32'h3928_3928, 64'h0, E1, 3'b101);
		run(BIG, 32'h2000_0000, 32'h1000_0000, 32'h3928_3928, 64'h0, E1, 3'b001);
		run(BIG, 32'h2000_0000, 32'h1000_0000, 32'h3928_3928, 64'h0, E1, 3'b101);
		run(BIG, 32'h2000_0000, 32'h1000_0000, 32'h3928_3928, 64'h0, E075, 3'b101);
		complete_run();
	end
endmodule
bind vafe_front_end vafe_front_end_monitor #(.BUF_DEPTH(BUF_DEPTH)) mon (.clk, .nrst, .in_valid, .in_ready,
	.decision_threshold, .out_valid, .out_ready, .filtered_energy, .steady_spectrum_flag, .periodic_flag,
	.speech_flag);

// file: verif/vafe_enc_model.sv
// vafe_enc_model: encoder side offering one frame of analysis values per call.
// assumes send is entered just after a rising edge of clk.
`timescale 1ns/1ps
module vafe_enc_model (
	// clock
	input wire logic clk,
	// frame handshake
	input wire logic in_ready,
	output logic in_valid,
	output logic signed [vafe_pkg::ACF_W-1:0] frame_autocorr [vafe_pkg::NCOEF],
	output logic [vafe_pkg::LAG_W-1:0] pitch_lag [4]
);
	initial begin
		in_valid = 1'b0;
		frame_autocorr = '{default: '0};
		pitch_lag = '{default: '0};
	end
	// values from 16-bit samples, four lags, held until taken or until 64 edges pass
	// lags above two halve from index two, a smooth spectrum that exercises the solve
	task automatic send(input logic signed [31:0] a0, a1, a2, input logic [31:0] lg, output bit ok);
		int n;
		ok = 1'b0;
		frame_autocorr = '{default: '0};
		frame_autocorr[0] = a0;
		frame_autocorr[1] = a1;
		frame_autocorr[2] = a2;
		for (n = 3; n < vafe_pkg::NCOEF; n++)
			frame_autocorr[n] = frame_autocorr[n - 1] >>> 1;
		pitch_lag = '{lg[31:24], lg[23:16], lg[15:8], lg[7:0]};
		in_valid = 1'b1;
		for (n = 0; n < 64 && !ok; n++) begin
			ok = (in_ready === 1'b1);
			@(posedge clk);
			#1;
		end
		in_valid = 1'b0;
		// released lines show the inverse, never a stale frame
		foreach (frame_autocorr[i]) frame_autocorr[i] = ~frame_autocorr[i];
		foreach (pitch_lag[i]) pitch_lag[i] = ~pitch_lag[i];
		// one idle edge, so a following call never drives the strobe twice in one step
		@(posedge clk);
		#1;
	endtask
endmodule

// file: verif/vafe_front_end_monitor.sv
// vafe_front_end_monitor: port checks of the frame and result handshakes.
// assumes it is bound to vafe_front_end and sees only its ports.
`timescale 1ns/1ps
module vafe_front_end_monitor #(
	parameter int BUF_DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// frame side
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic [vafe_pkg::ENERGY_W-1:0] decision_threshold,
	// result side
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [vafe_pkg::ENERGY_W-1:0] filtered_energy,
	input wire logic steady_spectrum_flag,
	input wire logic periodic_flag,
	input wire logic speech_flag
);
	logic [3:0] pending;
	logic [3:0] next_pending;
	wire take = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	// frames held inside, engine plus buffer
	assign next_pending = pending + {3'h0, take} - {3'h0, pop};
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			pending <= 4'h0;
		else
			pending <= next_pending;
	end
	take_closes_a: assert property (@(posedge clk) disable iff (!nrst) take |=> !in_ready)
		else $error("frame port stayed open after a take");
	word_latency_a: assert property (@(posedge clk) disable iff (!nrst)
		take && !out_valid |=> (!out_valid)[*8] ##1 (!out_valid)[*2] ##1 out_valid)
		else $error("result word not on time");
	word_holds_a: assert property (@(posedge clk) disable iff (!nrst) out_valid && !out_ready |=>
		out_valid && $stable(filtered_energy) && $stable({steady_spectrum_flag, periodic_flag, speech_flag}))
		else $error("result word changed while stalled");
	reopen_with_word_a: assert property (@(posedge clk) disable iff (!nrst) $rose(in_ready) |-> out_valid)
		else $error("frame port reopened without a result");
	speech_decision_a: assert property (@(posedge clk) disable iff (!nrst)
		out_valid |-> speech_flag == (filtered_energy > decision_threshold))
		else $error("speech flag disagrees with energy");
	reset_idle_a: assert property (@(posedge clk) !nrst |-> in_ready && !out_valid)
		else $error("ports not idle in reset");
	no_spare_word_a: assert property (@(posedge clk) disable iff (!nrst) out_valid |-> pending != 4'h0)
		else $error("result word without a frame");
	full_stalls_a: assert property (@(posedge clk) disable iff (!nrst)
		pending == 4'(BUF_DEPTH + 1) |-> !in_ready)
		else $error("frame taken while buffer full");
endmodule

// file: verilog/vafe_front_end.sv
// vafe_front_end: per-frame energy, stationarity and periodicity front end.
// assumes the encoder presents one frame's analysis values per strobe and
// that threshold adaptation and the final hangover sit outside this block.
// Function
// - filtered energy from adaptive filter and autocorrelation
// - recent sum spans four frames, starts zero
// - delayed sum is recent sum four frames back
// - solve Toeplitz system, first coefficient one
// - predictor autocorrelation over coefficient products
// - distortion from predictor and recent sums
// - steady when distortion change below 0.05
// - periodic when two past counts reach four
// - count lag pairs near integer multiples
// - lag counts shift after decision, start zero
// - first pair uses previous last lag, 40
// - adapt filter only when steady and aperiodic
// - speech when filtered energy exceeds threshold
// - exactly one output set per frame
`timescale 1ns/1ps
module vafe_front_end #(
	parameter int BUF_DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// frame input from the encoder
	input wire logic in_valid,
	output logic in_ready,
	input wire logic signed [vafe_pkg::ACF_W-1:0] frame_autocorr [vafe_pkg::NCOEF],
	input wire logic [vafe_pkg::LAG_W-1:0] pitch_lag [4],
	// control from the threshold stage
	input wire logic [vafe_pkg::ENERGY_W-1:0] decision_threshold,
	input wire logic adapt_enable,
	// per-frame results
	output logic out_valid,
	input wire logic out_ready,
	output logic [vafe_pkg::ENERGY_W-1:0] filtered_energy,
	output logic steady_spectrum_flag,
	output logic periodic_flag,
	output logic speech_flag
);
	localparam int N = vafe_pkg::NCOEF;
	localparam int OW = vafe_pkg::ENERGY_W + 3;

	vafe_pkg::vafe_state_t state;
	logic signed [vafe_pkg::SUM_W-1:0] acf_hist [vafe_pkg::AVG_DEPTH-1][N];
	logic signed [vafe_pkg::SUM_W-1:0] sum_hist [vafe_pkg::AVG_DEPTH][N];
	logic signed [vafe_pkg::SUM_W-1:0] recent_acf_sum [N];
	logic signed [vafe_pkg::SUM_W-1:0] delayed_acf_sum [N];
	logic signed [vafe_pkg::COEF_W-1:0] coef [N];
	logic signed [vafe_pkg::RAV_W-1:0] rvad [N];
	logic signed [vafe_pkg::ERR_W-1:0] err;
	logic signed [vafe_pkg::RAV_W-1:0] previous_distortion;
	logic [3:0] ord;
	logic [vafe_pkg::LAG_W-1:0] lag [4];
	logic [vafe_pkg::LAG_W-1:0] last_lag;
	logic [2:0] lag_matches_prev;
	logic [2:0] lag_matches_prev2;
	logic [vafe_pkg::ENERGY_W-1:0] energy;
	logic steady;
	logic periodic;
	logic speech;

	// output buffer of BUF_DEPTH entries, two by default
	logic [OW-1:0] buf_mem [BUF_DEPTH];
	logic [$clog2(BUF_DEPTH+1)-1:0] buf_cnt;
	logic buf_rd;
	logic buf_wr;
	logic buf_full;

	// input acceptance only between frames
	assign in_ready = (state == vafe_pkg::VAFE_IDLE);
	assign buf_full = (buf_cnt == BUF_DEPTH);
	assign out_valid = (buf_cnt != 0);
	assign buf_rd = out_valid && out_ready;
	assign buf_wr = (state == vafe_pkg::VAFE_OUT) && !buf_full;
	assign {filtered_energy, steady_spectrum_flag, periodic_flag, speech_flag} = buf_mem[0];

	// averaging over the current and three stored frames
	logic signed [vafe_pkg::SUM_W-1:0] next_recent [N];
	always_comb begin
		for (int i = 0; i < N; i++) begin
			next_recent[i] = vafe_pkg::SUM_W'(frame_autocorr[i]); // 16-bit samples fit in 40 bits
			for (int d = 0; d < vafe_pkg::AVG_DEPTH - 1; d++)
				next_recent[i] = next_recent[i] + acf_hist[d][i];
		end
	end

	// filtered energy, adaptive filter applied to this frame's autocorrelation
	logic signed [95:0] energy_acc;
	always_comb begin
		energy_acc = 96'(rvad[0] * frame_autocorr[0]);
		for (int i = 1; i < N; i++)
			energy_acc = energy_acc + 96'(2 * rvad[i] * frame_autocorr[i]);
	end

	// one levinson step per cycle; a wide divider is traded for a short frame latency
	logic signed [95:0] lev_acc;
	logic signed [95:0] lev_q;
	logic signed [vafe_pkg::COEF_W-1:0] refl;
	logic signed [vafe_pkg::COEF_W-1:0] next_coef [N];
	logic signed [127:0] err_drop;
	always_comb begin
		lev_acc = 96'(delayed_acf_sum[ord]) <<< vafe_pkg::FRAC;
		for (int j = 1; j < N; j++)
			if (j < int'(ord))
				lev_acc = lev_acc + 96'(coef[j] * delayed_acf_sum[int'(ord) - j]);
		// zero energy at start-up would divide by zero, so the step is skipped
		lev_q = (err > 0) ? -(lev_acc / 96'(err)) : 96'sh0;
		if (lev_q > 96'sh1_0000)
			refl = vafe_pkg::COEF_ONE;
		else if (lev_q < -96'sh1_0000)
			refl = -vafe_pkg::COEF_ONE;
		else
			refl = lev_q[vafe_pkg::COEF_W-1:0];
		for (int j = 0; j < N; j++) begin
			next_coef[j] = coef[j];
			if (j == int'(ord))
				next_coef[j] = refl;
			else if (j > 0 && j < int'(ord))
				next_coef[j] = coef[j] + 32'((64'(refl) * coef[int'(ord) - j]) >>> vafe_pkg::FRAC);
		end
		err_drop = (128'(err) * refl * refl) >>> (2 * vafe_pkg::FRAC);
	end

	// predictor autocorrelation; the first coefficient is held at one, so no sign needs cancelling
	logic signed [vafe_pkg::RAV_W-1:0] predictor_autocorr [N];
	always_comb begin
		for (int i = 0; i < N; i++) begin
			predictor_autocorr[i] = '0;
			for (int k = 0; k + i < N; k++)
				predictor_autocorr[i] = predictor_autocorr[i]
					+ 48'((64'(coef[k]) * coef[k + i]) >>> vafe_pkg::FRAC);
		end
	end

	// distortion measure against the recent sums
	logic signed [127:0] dm_num;
	logic signed [vafe_pkg::RAV_W-1:0] distortion_measure;
	logic signed [vafe_pkg::RAV_W-1:0] dm_diff;
	always_comb begin
		dm_num = 128'(predictor_autocorr[0] * recent_acf_sum[0]);
		for (int i = 1; i < N; i++)
			dm_num = dm_num + 128'(2 * predictor_autocorr[i] * recent_acf_sum[i]);
		distortion_measure = (recent_acf_sum[0] > 0) ? 48'(dm_num / 128'(recent_acf_sum[0])) : '0;
		dm_diff = distortion_measure - previous_distortion;
		if (dm_diff < 0)
			dm_diff = -dm_diff;
	end

	// lag pair matching, first pair against the last lag of the previous frame
	logic [2:0] lag_matches_now;
	logic [vafe_pkg::LAG_W-1:0] lag_a;
	logic [vafe_pkg::LAG_W-1:0] lag_b;
	logic [vafe_pkg::LAG_W-1:0] lag_small;
	logic [vafe_pkg::LAG_W-1:0] lag_remainder;
	logic [vafe_pkg::LAG_W-1:0] lag_near;
	always_comb begin
		lag_matches_now = '0;
		lag_small = '0;
		lag_remainder = '0;
		lag_near = '0;
		for (int j = 0; j < 4; j++) begin
			lag_a = lag[j];
			lag_b = (j == 0) ? last_lag : lag[j - 1];
			lag_small = (lag_a < lag_b) ? lag_a : lag_b;
			if (lag_small != '0) begin
				lag_remainder = ((lag_a < lag_b) ? lag_b : lag_a) % lag_small;
				lag_near = lag_small - lag_remainder;
				if (lag_near > lag_remainder)
					lag_near = lag_remainder;
				if (lag_near < vafe_pkg::LAG_TOLERANCE)
					lag_matches_now = lag_matches_now + 3'h1;
			end
		end
	end

	// frame sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= vafe_pkg::VAFE_IDLE;
			ord <= '0;
		end else begin
			unique case (state)
				vafe_pkg::VAFE_IDLE: begin
					if (in_valid)
						state <= vafe_pkg::VAFE_SOLVE;
					ord <= 4'h1;
				end
				vafe_pkg::VAFE_SOLVE: begin
					ord <= ord + 4'h1;
					if (ord == 4'(vafe_pkg::ORDER))
						state <= vafe_pkg::VAFE_SPEC;
				end
				vafe_pkg::VAFE_SPEC: state <= vafe_pkg::VAFE_OUT;
				vafe_pkg::VAFE_OUT: begin
					if (!buf_full)
						state <= vafe_pkg::VAFE_IDLE;
				end
			endcase
		end
	end

	// frame capture, averaging history and predictor solve
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < N; i++) begin
				for (int d = 0; d < vafe_pkg::AVG_DEPTH - 1; d++)
					acf_hist[d][i] <= '0;
				for (int d = 0; d < vafe_pkg::AVG_DEPTH; d++)
					sum_hist[d][i] <= '0;
				recent_acf_sum[i] <= '0;
				delayed_acf_sum[i] <= '0;
				coef[i] <= '0;
			end
			for (int j = 0; j < 4; j++)
				lag[j] <= '0;
			err <= '0;
			energy <= '0;
		end else if (state == vafe_pkg::VAFE_IDLE && in_valid) begin
			for (int i = 0; i < N; i++) begin
				acf_hist[0][i] <= vafe_pkg::SUM_W'(frame_autocorr[i]);
				for (int d = 1; d < vafe_pkg::AVG_DEPTH - 1; d++)
					acf_hist[d][i] <= acf_hist[d - 1][i];
				sum_hist[0][i] <= next_recent[i];
				for (int d = 1; d < vafe_pkg::AVG_DEPTH; d++)
					sum_hist[d][i] <= sum_hist[d - 1][i];
				recent_acf_sum[i] <= next_recent[i];
				delayed_acf_sum[i] <= sum_hist[vafe_pkg::AVG_DEPTH - 1][i];
				coef[i] <= (i == 0) ? vafe_pkg::COEF_ONE : '0;
			end
			for (int j = 0; j < 4; j++)
				lag[j] <= pitch_lag[j];
			err <= 48'(sum_hist[vafe_pkg::AVG_DEPTH - 1][0]);
			energy <= 64'(energy_acc >>> vafe_pkg::FRAC);
		end else if (state == vafe_pkg::VAFE_SOLVE) begin
			coef <= next_coef;
			err <= err - 48'(err_drop);
		end
	end

	// decision flags, adaptive filter and lag history
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			previous_distortion <= '0;
			steady <= 1'b0;
			periodic <= 1'b0;
			speech <= 1'b0;
			lag_matches_prev <= '0;
			lag_matches_prev2 <= '0;
			last_lag <= vafe_pkg::LAST_LAG_INIT;
			for (int i = 0; i < N; i++)
				rvad[i] <= (i == 0) ? vafe_pkg::RVAD0_INIT : (i == 1) ? vafe_pkg::RVAD1_INIT :
					(i == 2) ? vafe_pkg::RVAD2_INIT : '0;
		end else if (state == vafe_pkg::VAFE_SPEC) begin
			steady <= (dm_diff < vafe_pkg::SPECTRAL_LIMIT_Q);
			previous_distortion <= distortion_measure;
			periodic <= (4'(lag_matches_prev) + 4'(lag_matches_prev2)
				>= vafe_pkg::PERIODIC_COUNT_LIMIT);
			speech <= (energy > decision_threshold);
		end else if (state == vafe_pkg::VAFE_OUT && !buf_full) begin
			// counts move only at the edge that hands the decision on
			lag_matches_prev2 <= lag_matches_prev;
			lag_matches_prev <= lag_matches_now;
			last_lag <= lag[3];
			// voiced frames must not train the filter
			if (steady && !periodic && adapt_enable)
				rvad <= predictor_autocorr;
		end
	end

	// output buffer, holds results while the receiver stalls
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buf_cnt <= '0;
			for (int e = 0; e < BUF_DEPTH; e++)
				buf_mem[e] <= '0;
		end else begin
			if (buf_rd)
				for (int e = 0; e < BUF_DEPTH - 1; e++)
					buf_mem[e] <= buf_mem[e + 1];
			if (buf_wr)
				buf_mem[int'(buf_cnt) - (buf_rd ? 1 : 0)] <= {energy, steady, periodic, speech};
			buf_cnt <= buf_cnt + (buf_wr ? 1'b1 : 1'b0) - (buf_rd ? 1'b1 : 1'b0);
		end
	end
endmodule

// file: verilog/vafe_pkg.sv
// vafe_pkg: constants shared by the voice activity front end.
// assumes one frame of encoder analysis values is presented at a time.
package vafe_pkg;
	// averaging and predictor order
	localparam int AVG_DEPTH = 4;
	localparam int ORDER = 8;
	localparam int NCOEF = ORDER + 1;
	// data widths
	localparam int ACF_W = 32;
	localparam int SUM_W = 40;
	localparam int FRAC = 16;
	localparam int COEF_W = 32;
	localparam int RAV_W = 48;
	localparam int ERR_W = 48;
	localparam int ENERGY_W = 64;
	localparam int LAG_W = 8;
	// spectral comparison, limit in real units then in q16
	localparam real SPECTRAL_CHANGE_LIMIT = 0.05;
	localparam int SCL_Q = $rtoi(SPECTRAL_CHANGE_LIMIT * (2.0 ** FRAC));
	localparam logic signed [RAV_W-1:0] SPECTRAL_LIMIT_Q = RAV_W'(SCL_Q);
	// periodicity detection
	localparam logic [LAG_W-1:0] LAG_TOLERANCE = 8'h02;
	localparam logic [3:0] PERIODIC_COUNT_LIMIT = 4'h4;
	localparam logic [LAG_W-1:0] LAST_LAG_INIT = 8'h28;
	// adaptive filter start values and the unit coefficient, integers placed in q16
	localparam logic signed [RAV_W-1:0] RVAD0_INIT = 48'h0000_0006_0000;
	localparam logic signed [RAV_W-1:0] RVAD1_INIT = 48'hffff_fffc_0000;
	localparam logic signed [RAV_W-1:0] RVAD2_INIT = 48'h0000_0001_0000;
	localparam logic signed [COEF_W-1:0] COEF_ONE = 32'h0001_0000;
	// engine states
	typedef enum logic [1:0] {VAFE_IDLE, VAFE_SOLVE, VAFE_SPEC, VAFE_OUT} vafe_state_t;
endpackage
